// >>> ldma_ctrl.sv
// Seven-channel legacy DMA controller with a pair of sideband request channels.
//
// Contract
// - Seven independent channels built as two cascaded classic controller cores.
// - Channels zero to three move bytes; count drops once per byte.
// - Channels five to seven move words; count drops once per word.
// - Channel four never transfers; it is the generic bus-master request.
// - At most two channels at once may use fast transfer timing.
// - Single, demand, verify and incrementing transfer modes are served.
// - Two sideband request channels are provided and act as a pair.
`timescale 1ns/100ps
`default_nettype none
module ldma_ctrl (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                resetn,
  // Channel programming from the host side.
  input  wire logic                prog_we,
  input  wire logic [2:0]          prog_ch,
  input  wire ldma_pkg::ldma_prog_t prog_data,
  // Peripheral requests from the low pin count side, asynchronous.
  input  wire logic [7:0]          dreq,
  // Paired sideband request lines, asynchronous.
  input  wire logic [1:0]          pci_sideband_dma_req,
  // Transfer issue and status.
  output logic                     prog_refused,
  output ldma_pkg::ldma_xfer_t     xfer,
  output logic [7:0]               tc_done,
  output logic [1:0]               pci_sideband_dma_gnt
);
  logic [15:0] addr [ldma_pkg::NUM_CH];
  logic [15:0] count [ldma_pkg::NUM_CH];
  ldma_pkg::ldma_mode_t mode [ldma_pkg::NUM_CH];
  logic [7:0] fast;
  logic [7:0] armed;
  logic [7:0] rq1, rq2, rq3, rq;
  logic [1:0] sb1, sb2, sb3, sb;
  logic [7:0] rq_agree;
  logic [1:0] sb_agree;
  logic [7:0] pend;
  logic [2:0] sel;
  logic       any;
  logic [1:0] fast_cnt;
  logic       accept;
  logic       last;
  logic       wide;

  // Three-stage synchronisers; a change counts once stages two and three agree.
  // Agreement is judged per line, so a bouncing request cannot delay a clean one.
  assign rq_agree = ~(rq2 ^ rq3);
  assign sb_agree = ~(sb2 ^ sb3);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rq1 <= 8'h00; rq2 <= 8'h00; rq3 <= 8'h00; rq <= 8'h00;
      sb1 <= 2'h0; sb2 <= 2'h0; sb3 <= 2'h0; sb <= 2'h0;
    end else begin
      rq1 <= dreq; rq2 <= rq1; rq3 <= rq2;
      rq  <= (rq_agree & rq3) | (~rq_agree & rq);
      sb1 <= pci_sideband_dma_req; sb2 <= sb1; sb3 <= sb2;
      sb  <= (sb_agree & sb3) | (~sb_agree & sb);
    end
  end

  // Channel four is masked out of service entirely.
  assign pend = rq & armed & ~(8'h01 << ldma_pkg::CH_RESERVED);

  // Fixed priority, lower number first, as in the cascaded cores.
  always_comb begin
    sel = 3'h0;
    any = 1'b0;
    for (int i = ldma_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (pend[i]) begin
        sel = 3'(i);
        any = 1'b1;
      end
    end
  end

  // Fast timing goes to a new channel only while fewer than two channels already hold it.
  always_comb begin
    fast_cnt = 2'h0;
    for (int i = 0; i < ldma_pkg::NUM_CH; i++) begin
      fast_cnt = fast_cnt + {1'b0, fast[i]};
    end
  end
  assign accept = prog_we && prog_ch != ldma_pkg::CH_RESERVED &&
                  !(prog_data.fast && !fast[prog_ch] &&
                    fast_cnt >= 2'(ldma_pkg::MAX_FAST));
  assign wide = sel > ldma_pkg::CH_LAST_BYTE;
  assign last = count[sel] == ldma_pkg::COUNT_ONE;

  genvar g;
  generate
    for (g = 0; g < ldma_pkg::NUM_CH; g++) begin : g_ch
      // Unit size follows the channel number and is fixed at build time.
      logic [15:0] unit_step;
      assign unit_step = (3'(g) > ldma_pkg::CH_LAST_BYTE) ? ldma_pkg::STEP_WORD
                                                           : ldma_pkg::STEP_BYTE;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          addr[g]  <= 16'h0000;
          count[g] <= 16'h0000;
          mode[g]  <= ldma_pkg::LDMA_SINGLE;
          fast[g]  <= 1'b0;
          armed[g] <= 1'b0;
        end else if (accept && prog_ch == 3'(g)) begin
          addr[g]  <= prog_data.addr;
          count[g] <= prog_data.count;
          mode[g]  <= prog_data.mode;
          fast[g]  <= prog_data.fast;
          armed[g] <= prog_data.count != 16'h0000;
        end else if (any && sel == 3'(g)) begin
          // Count drops once per unit moved; address steps by unit size except in verify mode.
          count[g] <= count[g] - ldma_pkg::COUNT_ONE;
          if (mode[g] == ldma_pkg::LDMA_INCR || mode[g] == ldma_pkg::LDMA_DEMAND ||
              mode[g] == ldma_pkg::LDMA_SINGLE) begin
            addr[g] <= addr[g] + unit_step;
          end
          if (last) begin
            armed[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Verify cycles run the count but hold the address and never write memory.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xfer         <= '0;
      tc_done      <= 8'h00;
      prog_refused <= 1'b0;
      pci_sideband_dma_gnt <= 2'h0;
    end else begin
      xfer.valid    <= any;
      xfer.ch       <= sel;
      xfer.addr     <= addr[sel];
      xfer.wide     <= wide;
      xfer.write_en <= mode[sel] != ldma_pkg::LDMA_VERIFY;
      xfer.fast     <= fast[sel];
      tc_done       <= (any && last) ? (8'h01 << sel) : 8'h00;
      prog_refused  <= prog_we && !accept;
      // The sideband pair is granted together only when both lines request.
      pci_sideband_dma_gnt <= (sb == 2'h3) ? 2'h3 : 2'h0;
    end
  end

  property p_no_ch4;
    @(posedge clk) disable iff (!resetn) xfer.valid |-> xfer.ch != ldma_pkg::CH_RESERVED;
  endproperty
  a_no_ch4: assert property (p_no_ch4) else $error("reserved channel issued");
  property p_fast_limit;
    @(posedge clk) disable iff (!resetn) fast_cnt <= 2'(ldma_pkg::MAX_FAST);
  endproperty
  a_fast_limit: assert property (p_fast_limit) else $error("too many fast channels");
  property p_width;
    @(posedge clk) disable iff (!resetn)
      xfer.valid |-> xfer.wide == (xfer.ch > ldma_pkg::CH_LAST_BYTE);
  endproperty
  a_width: assert property (p_width) else $error("width does not match channel");
  property p_step;
    @(posedge clk) disable iff (!resetn)
      (any && !accept && mode[sel] != ldma_pkg::LDMA_VERIFY && sel > ldma_pkg::CH_LAST_BYTE)
      |=> addr[$past(sel)] == $past(addr[sel]) + ldma_pkg::STEP_WORD;
  endproperty
  a_step: assert property (p_step) else $error("word address step wrong");
  property p_count;
    @(posedge clk) disable iff (!resetn)
      (any && !accept) |=> count[$past(sel)] == $past(count[sel]) - ldma_pkg::COUNT_ONE;
  endproperty
  a_count: assert property (p_count) else $error("count not decremented");
  property p_verify;
    @(posedge clk) disable iff (!resetn)
      (any && mode[sel] == ldma_pkg::LDMA_VERIFY) |=> !xfer.write_en;
  endproperty
  a_verify: assert property (p_verify) else $error("verify cycle wrote memory");
  property p_pair;
    @(posedge clk) disable iff (!resetn)
      pci_sideband_dma_gnt == 2'h0 || pci_sideband_dma_gnt == 2'h3;
  endproperty
  a_pair: assert property (p_pair) else $error("sideband grant split");
  property p_refuse;
    @(posedge clk) disable iff (!resetn)
      (prog_we && prog_ch == ldma_pkg::CH_RESERVED) |=> prog_refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("channel four program accepted");
  // A program that lands on the serviced channel wins, so step checks skip those cycles.
  property p_step_byte;
    @(posedge clk) disable iff (!resetn)
      (any && !accept && mode[sel] != ldma_pkg::LDMA_VERIFY && sel <= ldma_pkg::CH_LAST_BYTE)
      |=> addr[$past(sel)] == $past(addr[sel]) + ldma_pkg::STEP_BYTE;
  endproperty
  a_step_byte: assert property (p_step_byte) else $error("byte address step wrong");
  property p_verify_hold;
    @(posedge clk) disable iff (!resetn)
      (any && !accept && mode[sel] == ldma_pkg::LDMA_VERIFY)
      |=> addr[$past(sel)] == $past(addr[sel]);
  endproperty
  a_verify_hold: assert property (p_verify_hold) else $error("verify moved address");
  property p_tc_onehot;
    @(posedge clk) disable iff (!resetn)
      $onehot0(tc_done);
  endproperty
  a_tc_onehot: assert property (p_tc_onehot) else $error("two terminal counts");
  property p_tc_unit;
    @(posedge clk) disable iff (!resetn)
      tc_done != 8'h00 |-> xfer.valid && tc_done == (8'h01 << xfer.ch);
  endproperty
  a_tc_unit: assert property (p_tc_unit) else $error("terminal count without unit");
  property p_disarm;
    @(posedge clk) disable iff (!resetn)
      (any && last && !accept) |=> !armed[$past(sel)];
  endproperty
  a_disarm: assert property (p_disarm) else $error("armed after last unit");
  property p_fast_refuse;
    @(posedge clk) disable iff (!resetn)
      (prog_we && prog_data.fast && !fast[prog_ch] && fast_cnt == 2'(ldma_pkg::MAX_FAST))
      |=> prog_refused;
  endproperty
  a_fast_refuse: assert property (p_fast_refuse) else $error("third fast channel taken");
  property p_why_refused;
    @(posedge clk) disable iff (!resetn)
      prog_refused |-> $past(prog_we);
  endproperty
  a_why_refused: assert property (p_why_refused) else $error("refusal unasked");
  property p_pair_follow;
    @(posedge clk) disable iff (!resetn)
      (sb == 2'h3) |=> (pci_sideband_dma_gnt == 2'h3);
  endproperty
  a_pair_follow: assert property (p_pair_follow) else $error("pair not granted");
  property p_ch4_idle;
    @(posedge clk) disable iff (!resetn)
      !armed[ldma_pkg::CH_RESERVED];
  endproperty
  a_ch4_idle: assert property (p_ch4_idle) else $error("reserved channel armed");
endmodule
`default_nettype wire

// >>> ldma_periph.sv
// Peripheral model that raises and holds DMA requests.
`timescale 1ns/100ps
`default_nettype none
module ldma_periph (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       resetn,
  // Requests wanted by the bench.
  input  wire logic [7:0] want,
  // Request levels to the controller.
  output logic      [7:0] dreq
);
  // Levels only, so each mode is gated by how long the bench holds a request.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dreq <= 8'h00;
    end else begin
      dreq <= want;
    end
  end
endmodule
`default_nettype wire

// >>> ldma_pkg.sv
// Package with the shared constants and carrier types of the legacy DMA channel controller.
package ldma_pkg;
  localparam int NUM_CH      = 8;
  localparam int CH_W        = 3;
  localparam logic [2:0] CH_RESERVED = 3'h4;
  localparam logic [2:0] CH_LAST_BYTE = 3'h3;
  localparam int MAX_FAST    = 2;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  typedef enum logic [1:0] {
    LDMA_SINGLE = 2'b00,
    LDMA_DEMAND = 2'b01,
    LDMA_VERIFY = 2'b10,
    LDMA_INCR   = 2'b11
  } ldma_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] count;
    ldma_mode_t  mode;
    logic        fast;
  } ldma_prog_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  ch;
    logic [15:0] addr;
    logic        wide;
    logic        write_en;
    logic        fast;
  } ldma_xfer_t;
endpackage

// >>> testbench.sv
// Self-checking bench for the legacy DMA controller.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                 clk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 prog_we = 1'b0;
  logic [2:0]           prog_ch = 3'h0;
  ldma_pkg::ldma_prog_t prog_data = '0;
  logic [7:0]           want = 8'h00;
  logic [7:0]           dreq;
  logic [1:0]           sb_req = 2'h0;
  logic                 prog_refused;
  ldma_pkg::ldma_xfer_t xfer;
  logic [7:0]           tc_done;
  logic [1:0]           sb_gnt;
  int                   bad_count = 0;
  int                   check_count = 0;
  always #5 clk = ~clk;
  ldma_periph ldma_periph_inst (.clk(clk), .resetn(resetn), .want(want), .dreq(dreq));
  ldma_ctrl ldma_ctrl_inst (.clk(clk), .resetn(resetn), .prog_we(prog_we), .prog_ch(prog_ch),
    .prog_data(prog_data), .dreq(dreq), .pci_sideband_dma_req(sb_req),
    .prog_refused(prog_refused), .xfer(xfer), .tc_done(tc_done), .pci_sideband_dma_gnt(sb_gnt));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // The refusal pulse is caught over two samples, as its exact cycle is the design's choice.
  task automatic prog(input logic [2:0] ch, input logic [15:0] n, input logic f,
                      input ldma_pkg::ldma_mode_t m, output logic r);
    prog_we = 1'b1;
    prog_ch = ch;
    prog_data = '{addr: 16'h0100, count: n, mode: m, fast: f};
    step();
    prog_we = 1'b0;
    r = prog_refused;
    step();
    r = r | prog_refused;
  endtask
  task automatic move(input logic [2:0] ch, input ldma_pkg::ldma_mode_t m, input logic f);
    logic        r;
    logic [15:0] st;
    st = (m == ldma_pkg::LDMA_VERIFY) ? 16'h0000 :
         (ch > ldma_pkg::CH_LAST_BYTE) ? ldma_pkg::STEP_WORD : ldma_pkg::STEP_BYTE;
    prog(ch, 16'h0002, f, m, r);
    chk("prog taken", 16'h0000, {15'h0, r});
    want[ch] = 1'b1;
    for (int i = 0; i < 20 && xfer.valid !== 1'b1; i++) step();
    chk("unit0", {9'h0, ch, f, ch > 3'h3, m != ldma_pkg::LDMA_VERIFY, 1'b1},
        {9'h0, xfer.ch, xfer.fast, xfer.wide, xfer.write_en, xfer.valid});
    chk("unit0 addr", 16'h0100, xfer.addr);
    step();
    chk("unit1 addr", 16'h0100 + st, xfer.addr);
    chk("unit1 tc", {8'h00, 8'h01 << ch}, {8'h00, tc_done});
    step();
    chk("unit2 valid", 16'h0000, {15'h0, xfer.valid});
    want[ch] = 1'b0;
    repeat (8) step();
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  // A request on channel four must neither be programmed nor move anything.
  task automatic reserved_test;
    logic r;
    prog(ldma_pkg::CH_RESERVED, 16'h0001, 1'b0, ldma_pkg::LDMA_INCR, r);
    chk("ch4 refused", 16'h0001, {15'h0, r});
    want[ldma_pkg::CH_RESERVED] = 1'b1;
    repeat (10) step();
    chk("ch4 idle", 16'h0000, {15'h0, xfer.valid});
    want[ldma_pkg::CH_RESERVED] = 1'b0;
    repeat (8) step();
  endtask
  // Channels zero and six take fast timing; a third channel must be refused.
  task automatic fast_test;
    logic r;
    prog(3'h0, 16'h0001, 1'b1, ldma_pkg::LDMA_INCR, r);
    chk("fast one", 16'h0000, {15'h0, r});
    prog(3'h6, 16'h0001, 1'b1, ldma_pkg::LDMA_INCR, r);
    chk("fast two", 16'h0000, {15'h0, r});
    prog(3'h3, 16'h0001, 1'b1, ldma_pkg::LDMA_INCR, r);
    chk("fast three", 16'h0001, {15'h0, r});
  endtask
  task automatic pair_test;
    sb_req = 2'h3;
    for (int i = 0; i < 20 && sb_gnt !== 2'h3; i++) step();
    chk("pair grant", 16'h0003, {14'h0, sb_gnt});
    sb_req = 2'h1;
    repeat (10) step();
    chk("half pair", 16'h0000, {14'h0, sb_gnt});
    sb_req = 2'h0;
    step();
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    step();
    for (int k = 0; k < 4; k++) move(3'h1, ldma_pkg::ldma_mode_t'(k), 1'b0);
    move(3'h5, ldma_pkg::LDMA_INCR, 1'b0);
    move(3'h7, ldma_pkg::LDMA_VERIFY, 1'b0);
    reserved_test();
    fast_test();
    move(3'h0, ldma_pkg::LDMA_DEMAND, 1'b1);
    move(3'h6, ldma_pkg::LDMA_SINGLE, 1'b1);
    pair_test();
    wrap_up();
  end
endmodule
`default_nettype wire
